// *** core/sbp_pkg.sv ***
// package for the buffered serial port: register map, field positions, reset values
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
package sbp_pkg;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_CFG = 4'h8;
	localparam int STAT_EN = 15;
	localparam int STAT_HALT = 13;
	localparam int STAT_OVF = 6;
	localparam int STAT_TBF = 1;
	localparam int STAT_RBF = 0;
	localparam int CFG_MASTER = 0;
	localparam int CFG_DIV_LO = 8;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [7:0] DIV_RESET = 8'h04;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [1:0] {SBP_IDLE, SBP_SHIFT, SBP_DONE} sbp_state_t;
endpackage

// *** core/sbp_sync.sv ***
// two-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk; first flop feeds only the second
`timescale 1ns/1ns
module sbp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// *** core/sbp_top.sv ***
// buffered serial port: double-buffered 16-bit data, hidden shifter, status register
// assumes avalon-mm master on clk; pins asynchronous; tri-state resolved outside
`timescale 1ns/1ns
module sbp_top #(
	parameter int WORD_W = sbp_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_pin_oe_n,
	input wire logic select_or_sync_pin_i,
	output logic select_or_sync_pin_o,
	output logic select_or_sync_pin_oe_n,
	output logic port_busy
);
	logic [WORD_W-1:0] tx_hold_reg;
	logic [WORD_W-1:0] rx_hold_reg;
	logic [WORD_W-1:0] shifter_reg;
	logic [15:0] stat_reg;
	logic master_reg;
	logic [7:0] div_reg;
	logic [7:0] div_cnt_reg;
	logic [$clog2(WORD_W+1)-1:0] bit_cnt_reg;
	logic sclk_out_reg;
	logic sel_out_reg;
	logic sin_sample_reg;
	logic ack_reg;
	sbp_pkg::sbp_state_t state_reg;
	logic [2:0] pin_s;
	logic sclk_s;
	logic sel_n_s;
	logic sin_s;
	logic sclk_prev_reg;
	logic ext_rise;
	logic ext_fall;
	logic int_rise;
	logic int_fall;
	logic rise;
	logic fall;
	logic enabled;
	logic wr_data;
	logic wr_stat;
	logic wr_cfg;
	logic rd_data;
	logic load_shift;
	logic word_done;
	logic rx_room;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	// pins pass two flops before any use
	sbp_sync #(.W(3)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.d({shift_clock_pin_i, select_or_sync_pin_i, serial_in_pin}),
		.q(pin_s)
	);
	assign sclk_s = pin_s[2];
	assign sel_n_s = pin_s[1];
	assign sin_s = pin_s[0];

	// bus: one-cycle wait, answer on the second edge of a request
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else if (ce)
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign wr_data = avs_write && ack_reg && ce && hit(avs_address, sbp_pkg::OFS_DATA);
	assign wr_stat = avs_write && ack_reg && ce && hit(avs_address, sbp_pkg::OFS_STAT);
	assign wr_cfg = avs_write && ack_reg && ce && hit(avs_address, sbp_pkg::OFS_CFG);
	assign rd_data = avs_read && ack_reg && ce && hit(avs_address, sbp_pkg::OFS_DATA);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_readdata <= sbp_pkg::UNMAPPED_READ;
		else if (ce && avs_read && !ack_reg)
		begin
			if (hit(avs_address, sbp_pkg::OFS_DATA))
				avs_readdata <= {16'h0000, rx_hold_reg};
			else if (hit(avs_address, sbp_pkg::OFS_STAT))
				avs_readdata <= {16'h0000, stat_reg};
			else if (hit(avs_address, sbp_pkg::OFS_CFG))
				avs_readdata <= {16'h0000, div_reg, 7'h00, master_reg};
			else
				avs_readdata <= sbp_pkg::UNMAPPED_READ;
		end
	end

	// configuration: master select and clock divider
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			master_reg <= 1'b0;
			div_reg <= sbp_pkg::DIV_RESET;
		end
		else if (wr_cfg && avs_byteenable[0])
		begin
			master_reg <= avs_writedata[sbp_pkg::CFG_MASTER];
			if (avs_byteenable[1])
				div_reg <= avs_writedata[sbp_pkg::CFG_DIV_LO +: 8];
		end
	end

	assign enabled = stat_reg[sbp_pkg::STAT_EN];
	// halt_in_idle is stored only; this block has no idle-mode input
	assign load_shift = (state_reg == sbp_pkg::SBP_IDLE) && stat_reg[sbp_pkg::STAT_TBF] && enabled
		&& (master_reg || !sel_n_s);
	assign word_done = (state_reg == sbp_pkg::SBP_DONE);
	// a read finishing on the arrival edge frees the holder, so the new word is kept
	assign rx_room = !stat_reg[sbp_pkg::STAT_RBF] || rd_data;

	// transmit holding register, write only from software
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tx_hold_reg <= '0;
		else if (wr_data)
			tx_hold_reg <= avs_writedata[WORD_W-1:0];
	end

	// status: set beats clear for every hardware flag
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			stat_reg <= sbp_pkg::STAT_RESET;
		else if (ce)
		begin
			if (wr_stat && avs_byteenable[1])
			begin
				stat_reg[sbp_pkg::STAT_EN] <= avs_writedata[sbp_pkg::STAT_EN];
				stat_reg[sbp_pkg::STAT_HALT] <= avs_writedata[sbp_pkg::STAT_HALT];
			end
			if (word_done && !rx_room)
				stat_reg[sbp_pkg::STAT_OVF] <= 1'b1;
			else if (wr_stat && avs_byteenable[0] && !avs_writedata[sbp_pkg::STAT_OVF])
				stat_reg[sbp_pkg::STAT_OVF] <= 1'b0;
			if (wr_data)
				stat_reg[sbp_pkg::STAT_TBF] <= 1'b1;
			else if (load_shift)
				stat_reg[sbp_pkg::STAT_TBF] <= 1'b0;
			if (word_done)
				stat_reg[sbp_pkg::STAT_RBF] <= 1'b1;
			else if (rd_data)
				stat_reg[sbp_pkg::STAT_RBF] <= 1'b0;
		end
	end

	// receive holding register, filled when empty or read on the arrival edge
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rx_hold_reg <= '0;
		else if (ce && word_done && rx_room)
			rx_hold_reg <= shifter_reg;
	end

	// internal shift clock divider, runs only in master shifts
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_cnt_reg <= '0;
			sclk_out_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (state_reg != sbp_pkg::SBP_SHIFT || !master_reg)
			begin
				div_cnt_reg <= '0;
				sclk_out_reg <= 1'b0;
			end
			else if (div_cnt_reg + 8'h01 >= div_reg)
			begin
				div_cnt_reg <= '0;
				sclk_out_reg <= !sclk_out_reg;
			end
			else
				div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end
	assign int_rise = master_reg && !sclk_out_reg && (div_cnt_reg + 8'h01 >= div_reg);
	assign int_fall = master_reg && sclk_out_reg && (div_cnt_reg + 8'h01 >= div_reg);

	// external shift clock edges
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sclk_prev_reg <= 1'b0;
		else if (ce)
			sclk_prev_reg <= sclk_s;
	end
	assign ext_rise = !master_reg && sclk_s && !sclk_prev_reg;
	assign ext_fall = !master_reg && !sclk_s && sclk_prev_reg;
	assign rise = int_rise || ext_rise;
	assign fall = int_fall || ext_fall;

	// shifter state machine: sample on rise, shift on fall, msb first
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= sbp_pkg::SBP_IDLE;
			shifter_reg <= '0;
			bit_cnt_reg <= '0;
			sin_sample_reg <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_reg)
				sbp_pkg::SBP_IDLE:
					if (load_shift)
					begin
						shifter_reg <= tx_hold_reg;
						bit_cnt_reg <= '0;
						state_reg <= sbp_pkg::SBP_SHIFT;
					end
				sbp_pkg::SBP_SHIFT:
					if (!enabled || (!master_reg && sel_n_s))
						state_reg <= sbp_pkg::SBP_IDLE;
					else if (rise)
						sin_sample_reg <= sin_s;
					else if (fall)
					begin
						shifter_reg <= {shifter_reg[WORD_W-2:0], sin_sample_reg};
						if (bit_cnt_reg == ($clog2(WORD_W+1))'(WORD_W-1))
							state_reg <= sbp_pkg::SBP_DONE;
						else
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end
				sbp_pkg::SBP_DONE:
					state_reg <= sbp_pkg::SBP_IDLE;
			endcase
		end
	end

	// frame select driven low by master for the whole word
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sel_out_reg <= 1'b1;
		else if (ce)
			sel_out_reg <= !(master_reg && state_reg == sbp_pkg::SBP_SHIFT);
	end

	assign serial_out_pin = shifter_reg[WORD_W-1];
	assign shift_clock_pin_o = sclk_out_reg;
	assign shift_clock_pin_oe_n = !(master_reg && enabled);
	assign select_or_sync_pin_o = sel_out_reg;
	assign select_or_sync_pin_oe_n = !(master_reg && enabled);
	assign port_busy = (state_reg != sbp_pkg::SBP_IDLE);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// bus and register access
	a_tx_write_flag: assert property (wr_data |=> stat_reg[sbp_pkg::STAT_TBF])
		else $error("transmit full not set after data write");
	a_tx_hold_load: assert property (wr_data |=> tx_hold_reg == $past(avs_writedata[WORD_W-1:0]))
		else $error("transmit holding register missed the write");
	a_rx_read_path: assert property (ce && avs_read && !ack_reg && avs_address == sbp_pkg::OFS_DATA
		|=> avs_readdata[15:0] == $past(rx_hold_reg))
		else $error("data read did not return receive holding register");
	a_unmapped_read: assert property (ce && avs_read && !ack_reg
		&& !hit(avs_address, sbp_pkg::OFS_DATA) && !hit(avs_address, sbp_pkg::OFS_STAT)
		&& !hit(avs_address, sbp_pkg::OFS_CFG) |=> avs_readdata == sbp_pkg::UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_wait_one: assert property ((avs_read || avs_write) && !ack_reg && ce |=> !avs_waitrequest)
		else $error("bus answer late");

	// status flags
	a_rx_hold_stable: assert property (stat_reg[sbp_pkg::STAT_RBF] && ce && !rd_data
		|=> $stable(rx_hold_reg))
		else $error("full receive register overwritten");
	a_overflow_set: assert property (ce && word_done && !rx_room
		|=> stat_reg[sbp_pkg::STAT_OVF])
		else $error("overflow not flagged");
	a_overflow_sticky: assert property (ce && stat_reg[sbp_pkg::STAT_OVF] && !(wr_stat && avs_byteenable[0])
		|=> stat_reg[sbp_pkg::STAT_OVF])
		else $error("overflow lost without a clear");
	a_rx_full_set: assert property (ce && word_done |=> stat_reg[sbp_pkg::STAT_RBF])
		else $error("receive full not set on arrival");
	a_rx_read_clear: assert property (rd_data && !word_done |=> !stat_reg[sbp_pkg::STAT_RBF])
		else $error("receive full not cleared by data read");
	a_load_clears: assert property (ce && load_shift && !wr_data
		|=> !stat_reg[sbp_pkg::STAT_TBF] && state_reg == sbp_pkg::SBP_SHIFT)
		else $error("transmit full not cleared on move");
	a_tx_flag_hold: assert property (ce && !stat_reg[sbp_pkg::STAT_TBF] && !wr_data
		|=> !stat_reg[sbp_pkg::STAT_TBF])
		else $error("transmit full set without a write");

	// shifter
	a_load_msb: assert property (ce && load_shift |=> serial_out_pin == $past(tx_hold_reg[WORD_W-1]))
		else $error("first bit not presented at load");
	a_rise_sample: assert property (ce && state_reg == sbp_pkg::SBP_SHIFT && rise
		&& enabled && (master_reg || !sel_n_s) |=> sin_sample_reg == $past(sin_s))
		else $error("input bit not sampled on rise");
	a_fall_shift: assert property (ce && state_reg == sbp_pkg::SBP_SHIFT && !rise && fall
		&& enabled && (master_reg || !sel_n_s)
		|=> shifter_reg == {$past(shifter_reg[WORD_W-2:0]), $past(sin_sample_reg)})
		else $error("shifter did not move on fall");
	a_done_once: assert property (ce && word_done |=> state_reg == sbp_pkg::SBP_IDLE)
		else $error("done state held too long");

	// pins
	a_clock_idle: assert property (ce && !(master_reg && state_reg == sbp_pkg::SBP_SHIFT)
		|=> !shift_clock_pin_o)
		else $error("shift clock not idle low outside a master word");
	a_select_frame: assert property (ce && master_reg && state_reg == sbp_pkg::SBP_SHIFT
		|=> !select_or_sync_pin_o)
		else $error("select not low during master word");
	a_select_idle: assert property (ce && !master_reg |=> select_or_sync_pin_o)
		else $error("select output low as slave");

	c_word_done: cover property (word_done);
	c_overflow: cover property (ce && word_done && !rx_room);
	c_busy_write: cover property (port_busy && wr_data);
	c_master_word: cover property (master_reg && word_done);
	c_read_on_arrival: cover property (word_done && rd_data);
endmodule

// *** testbench/sbp_peer.sv ***
// far-side serial master model: makes shift clock and select, swaps 16-bit words
// assumes the device runs as slave, sampling on the rise, clock idling low
`timescale 1ns/1ns
module sbp_peer (
	output logic sclk,
	output logic sel_n,
	output logic miso,
	input wire logic mosi
);
	initial
	begin
		sclk = 1'b0;
		sel_n = 1'b1;
		miso = 1'b0;
	end
	// 48 ns link clock, still between words; select lead leaves room for the load
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		sel_n <= 1'b0;
		#48;
		for (int i = 15; i >= 0; i--)
		begin
			miso <= tx[i];
			#24 sclk <= 1'b1;
			rx[i] = mosi;
			#24 sclk <= 1'b0;
		end
		// released with no pull: show the inverse, never a stale level
		// select lifts one cycle after the last fall: the word completes, yet no reload starts
		#4 miso <= ~miso;
		sel_n <= 1'b1;
	endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench: slave-mode traffic against the peer model, then a master check
// assumes sbp_peer drives the pins while the device does not
`timescale 1ns/1ns
module tb;
	logic clk;
	logic sys_rst;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sdo;
	logic sdi;
	logic sck_p;
	logic sck_o;
	logic sck_oe_n;
	logic sel_p;
	logic sel_o;
	logic sel_oe_n;
	logic busy;
	logic [15:0] got;
	logic [31:0] q;
	wire logic sck_w;
	wire logic sel_w;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	// device wins the pin only while its enable is low
	assign sck_w = sck_oe_n ? sck_p : sck_o;
	assign sel_w = sel_oe_n ? sel_p : sel_o;
	sbp_top sbp_top_i (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_in_pin(sdi), .serial_out_pin(sdo), .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
		.shift_clock_pin_oe_n(sck_oe_n), .select_or_sync_pin_i(sel_w), .select_or_sync_pin_o(sel_o),
		.select_or_sync_pin_oe_n(sel_oe_n), .port_busy(busy));
	sbp_peer sbp_peer_i (.sclk(sck_p), .sel_n(sel_p), .miso(sdi), .mosi(sdo));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one edge passes first, so a release is never overwritten in the same step
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		avs_write <= wr;
		avs_read <= ~wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, exp, q);
	endtask
	task automatic wait_busy(input logic lvl);
		for (int n = 0; n < 200 && busy !== lvl; n++)
			@(posedge clk);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk(sbp_pkg::OFS_STAT, {16'h0000, sbp_pkg::STAT_RESET}, "status reset");
		rdchk(sbp_pkg::OFS_CFG, 32'h0000_0400, "config reset");
		rdchk(4'hc, sbp_pkg::UNMAPPED_READ, "unmapped");
		bus(1'b1, sbp_pkg::OFS_STAT, 32'h0000_8000);
		bus(1'b1, sbp_pkg::OFS_DATA, 32'h0000_a5c3);
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8002, "transmit full");
		rdchk(sbp_pkg::OFS_DATA, 32'h0000_0000, "receive side");
		fork
			sbp_peer_i.frame(16'h3c96, got);
			begin
				wait_busy(1'b1);
				rdchk(sbp_pkg::OFS_STAT, 32'h0000_8000, "moved");
				bus(1'b1, sbp_pkg::OFS_DATA, 32'h0000_1234);
			end
		join
		wait_busy(1'b0);
		chk("sent word", 32'h0000_a5c3, {16'h0000, got});
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8003, "both full");
		rdchk(sbp_pkg::OFS_DATA, 32'h0000_3c96, "received");
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8002, "receive read");
		sbp_peer_i.frame(16'h0f0f, got);
		wait_busy(1'b0);
		chk("second word", 32'h0000_1234, {16'h0000, got});
		bus(1'b1, sbp_pkg::OFS_DATA, 32'h0000_5555);
		sbp_peer_i.frame(16'hf0f0, got);
		wait_busy(1'b0);
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8041, "overflow");
		rdchk(sbp_pkg::OFS_DATA, 32'h0000_0f0f, "kept word");
		bus(1'b1, sbp_pkg::OFS_STAT, 32'h0000_8000);
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8000, "overflow cleared");
		bus(1'b1, sbp_pkg::OFS_CFG, 32'h0000_0401);
		bus(1'b1, sbp_pkg::OFS_DATA, 32'h0000_00ff);
		wait_busy(1'b1);
		// select output is registered one edge after the load: look once it has settled
		@(negedge clk);
		chk("clock driven", 32'h0000_0000, {31'h0000_0000, sck_oe_n});
		chk("select low", 32'h0000_0000, {31'h0000_0000, sel_w});
		for (int n = 0; n < 20 && sck_o !== 1'b1; n++)
			@(negedge clk);
		chk("master clock", 32'h0000_0001, {31'h0000_0000, sck_o});
		// input pin rests at the inverse of the peer's last bit, a one
		wait_busy(1'b0);
		rdchk(sbp_pkg::OFS_STAT, 32'h0000_8001, "master done");
		rdchk(sbp_pkg::OFS_DATA, 32'h0000_ffff, "master received");
		@(negedge clk);
		chk("select released", 32'h0000_0001, {31'h0000_0000, sel_w});
		wrap_up();
	end
endmodule
